// [hdl/rmisb_top.sv]
/*
 * remappable input select bank: fourteen input selector registers, thirteen
 * output map registers, write lock with unlock keys, shadow-copy monitor and
 * pin-to-peripheral routing.
 * assumes a one-cycle read port and pins synchronous to ref_clk.
 */
// Operation
// - provide 27 remap registers: 14 input, 13 output
// - accept remap writes only while the write lock is clear
// - each input selector routes pin n to its peripheral input; pins at or above PINS_PRESENT give the idle level
// - bits outside selector fields read as zero
// - irq one selector bits 12-8; irq two bits 4-0 separately
// - timer 3/5 clocks in 12-8, timer 2/4 clocks in 4-0
// - capture 2/4 in 12-8, 1/3 in 4-0, 5 alone in 4-0
// - compare fault b in 12-8, fault a in 4-0
// - serial one clear-to-send 12-8, receive 4-0
// - serial two clear-to-send 12-8, receive 4-0
// - spi one clock 12-8, data 4-0; select alone 4-0
// - spi two clock 12-8, data 4-0; select alone 4-0
// - input selectors reset to 11111, pin 31
// - compare registers to shadow copies; flag mismatch reset
// - one-shot option keeps the lock set until reset
`timescale 1ns/100ps
module rmisb_top
    import rmisb_pkg::*;
#(
    parameter int unsigned PINS_PRESENT = 26
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // configuration
    input wire logic one_shot_lock_option,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // pins
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_FUNCS-1:0] idle_level,
    // peripheral inputs, bit order as the selector index
    output logic [NUM_FUNCS-1:0] func_in_q,
    // status
    output logic remap_write_lock_q,
    output logic mismatch_reset_q
);

    ////////////////////////////////////////////////////////////////////////
    // selector index per register half; 31 means no field
    function automatic int unsigned field_func(input int unsigned r, input bit hi);
        int unsigned idx;
        idx = 31;
        case (r)
            0: idx = hi ? 0 : 31;                 // ext irq one
            1: idx = hi ? 31 : 1;                 // ext irq two
            2: idx = hi ? 3 : 2;                  // timer 3 / timer 2
            3: idx = hi ? 5 : 4;                  // timer 5 / timer 4
            4: idx = hi ? 7 : 6;                  // capture 2 / 1
            5: idx = hi ? 9 : 8;                  // capture 4 / 3
            6: idx = hi ? 31 : 10;                // capture 5
            7: idx = hi ? 12 : 11;                // fault b / fault a
            8: idx = hi ? 14 : 13;                // serial one cts / rx
            9: idx = hi ? 16 : 15;                // serial two cts / rx
            10: idx = hi ? 18 : 17;               // spi one clock / data
            11: idx = hi ? 31 : 19;               // spi one select
            12: idx = hi ? 21 : 20;               // spi two clock / data
            13: idx = hi ? 31 : 22;               // spi two select
            default: idx = 31;
        endcase
        return idx;
    endfunction : field_func

    rmisb_bus_s bus;
    rmisb_sel_s sel;
    logic [IN_REGS-1:0] [DATA_W-1:0] in_reg_q;
    logic [IN_REGS-1:0] [DATA_W-1:0] in_shadow_q;
    logic [OUT_REGS-1:0] [DATA_W-1:0] out_reg_q;
    logic [OUT_REGS-1:0] [DATA_W-1:0] out_shadow_q;
    logic [DATA_W-1:0] rdata_d;
    logic lock;
    logic [NUM_FUNCS-1:0] func_in;
    logic in_hit;
    logic out_hit;
    logic [ADDR_W-1:0] in_idx;
    logic [ADDR_W-1:0] out_idx;
    logic [IN_REGS-1:0] [DATA_W-1:0] in_mask;

    // functions 23 and up have no selector and stay low
    localparam logic [NUM_FUNCS-1:0] USED_FUNCS = 28'h07f_ffff;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign in_idx = reg_addr - OFS_IN_BASE;
    assign out_idx = reg_addr - OFS_OUT_BASE;
    assign in_hit = (reg_addr >= OFS_IN_BASE) && (in_idx < ADDR_W'(IN_REGS));
    assign out_hit = (reg_addr >= OFS_OUT_BASE) && (out_idx < ADDR_W'(OUT_REGS));

    ////////////////////////////////////////////////////////////////////////
    // field masks per input register
    genvar r;
    generate
        for (r = 0; r < IN_REGS; r++)
        begin : g_mask
            assign in_mask[r] = {3'h0, {SEL_W{HAS_HI[r]}}, 3'h0, {SEL_W{HAS_LO[r]}}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // write lock
    rmisb_lock u_lock
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .one_shot_lock_option(one_shot_lock_option),
        .bus(bus),
        .remap_write_lock(lock)
    );

    ////////////////////////////////////////////////////////////////////////
    // input selector registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < IN_REGS; i++)
                in_reg_q[i] <= {3'h0, SEL_RESET & {SEL_W{HAS_HI[i]}},
                    3'h0, SEL_RESET & {SEL_W{HAS_LO[i]}}};
        end
        else if (reg_wr && in_hit && !lock)
        begin
            in_reg_q[in_idx] <= reg_wdata & in_mask[in_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output map registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < OUT_REGS; i++)
                out_reg_q[i] <= OUT_RESET;
        end
        else if (reg_wr && out_hit && !lock)
        begin
            out_reg_q[out_idx] <= reg_wdata & OUT_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow copies follow only accepted writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < IN_REGS; i++)
                in_shadow_q[i] <= {3'h0, SEL_RESET & {SEL_W{HAS_HI[i]}},
                    3'h0, SEL_RESET & {SEL_W{HAS_LO[i]}}};
            for (int i = 0; i < OUT_REGS; i++)
                out_shadow_q[i] <= OUT_RESET;
        end
        else if (reg_wr && !lock)
        begin
            if (in_hit)
                in_shadow_q[in_idx] <= reg_wdata & in_mask[in_idx];
            if (out_hit)
                out_shadow_q[out_idx] <= reg_wdata & OUT_MASK;
        end
    end

    // mismatch is sticky until reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mismatch_reset_q <= 1'b0;
        else if ((in_reg_q != in_shadow_q) || (out_reg_q != out_shadow_q))
            mismatch_reset_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // selector extraction; absent halves never reach here
    always_comb
    begin
        sel = '0;
        for (int i = 0; i < IN_REGS; i++)
        begin
            if (HAS_HI[i])
                sel.sel[field_func(i, 1'b1)] = in_reg_q[i][HI_FIELD_LSB +: SEL_W];
            if (HAS_LO[i])
                sel.sel[field_func(i, 1'b0)] = in_reg_q[i][LO_FIELD_LSB +: SEL_W];
        end
    end

    rmisb_route #(.PINS_PRESENT(PINS_PRESENT)) u_route
    (
        .sel(sel),
        .pin_in(pin_in),
        .idle_level(idle_level),
        .func_in(func_in)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            func_in_q <= '0;
        else
            func_in_q <= func_in & USED_FUNCS;
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    always_comb
    begin
        rdata_d = '0;
        if (in_hit)
            rdata_d = in_reg_q[in_idx];
        else if (out_hit)
            rdata_d = out_reg_q[out_idx];
        else if (reg_addr == OFS_LOCK_CTRL)
            rdata_d = DATA_W'(lock) << LOCK_BIT;
        else if (reg_addr == OFS_STATUS)
            rdata_d = {15'h0000, mismatch_reset_q};
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rdata_d;
        else
            reg_rdata <= '0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            remap_write_lock_q <= 1'b0;
        else
            remap_write_lock_q <= lock;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_locked_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && in_hit && lock) |=> $stable(in_reg_q);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked write changed map");

    property p_write_takes;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && in_hit && !lock) |=> in_reg_q[$past(in_idx)] == ($past(reg_wdata) & in_mask[$past(in_idx)]);
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("accepted write lost");

    property p_unimpl_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && (in_hit || out_hit)) |=> (reg_rdata & 16'he0e0) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bits read nonzero");

    property p_read_value;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && in_hit && !reg_wr) |=> reg_rdata == in_reg_q[$past(in_idx)];
    endproperty
    a_read_value: assert property (p_read_value) else $error("read data wrong");

    property p_route_lag;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> func_in_q == $past(func_in & USED_FUNCS);
    endproperty
    a_route_lag: assert property (p_route_lag) else $error("routing not registered");

    property p_absent_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        (32'(sel.sel[0]) >= PINS_PRESENT) |=> func_in_q[0] == $past(idle_level[0]);
    endproperty
    a_absent_idle: assert property (p_absent_idle) else $error("absent pin not idle");

    property p_no_mismatch;
        @(posedge ref_clk) disable iff (!rst_n)
        ((in_reg_q == in_shadow_q) && (out_reg_q == out_shadow_q)) |=> $stable(mismatch_reset_q);
    endproperty
    a_no_mismatch: assert property (p_no_mismatch) else $error("false mismatch");

    property p_oneshot;
        @(posedge ref_clk) disable iff (!rst_n)
        (one_shot_lock_option && lock && $past(lock, 2)) |=> lock;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot lock cleared");

    c_unlock_write: cover property (@(posedge ref_clk) disable iff (!rst_n) !lock ##1 reg_wr && in_hit);
    c_lock_set: cover property (@(posedge ref_clk) disable iff (!rst_n) !lock ##1 lock);
    c_locked_try: cover property (@(posedge ref_clk) disable iff (!rst_n) lock && reg_wr && in_hit);

endmodule : rmisb_top

// [hdl/rmisb_pkg.sv]
/*
 * package for the remappable input select bank: register map, field layout,
 * reset values, unlock keys, selector half flags and carrier structs.
 * assumes a 16-bit register port with one-cycle read latency.
 */
package rmisb_pkg;

    // widths and counts
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned IN_REGS = 14;
    localparam int unsigned OUT_REGS = 13;
    localparam int unsigned NUM_FUNCS = 28;
    localparam int unsigned NUM_PINS = 32;

    // field positions
    localparam int unsigned LO_FIELD_LSB = 0;
    localparam int unsigned HI_FIELD_LSB = 8;

    // selector reset value: pin 31
    localparam logic [4:0] SEL_RESET = 5'h1f;
    localparam logic [DATA_W-1:0] OUT_RESET = 16'h0000;

    // register offsets; input bank at 0x00..0x0d, output bank at 0x10..0x1c
    localparam logic [ADDR_W-1:0] OFS_IN_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_OUT_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_LOCK_CTRL = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h21;

    // lock control word: unlock keys in low byte, lock bit at 6
    localparam logic [7:0] KEY_FIRST = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;
    localparam int unsigned LOCK_BIT = 6;

    // per input register: which halves hold a selector
    localparam logic [IN_REGS-1:0] HAS_LO = 14'h3ffe;
    localparam logic [IN_REGS-1:0] HAS_HI = 14'h17bd;

    // valid-bit masks for output registers
    localparam logic [DATA_W-1:0] OUT_MASK = 16'h1f1f;

    typedef enum logic [1:0]
    {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_OPEN = 2'b11
    } rmisb_key_e;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rmisb_bus_s;

    typedef struct packed
    {
        logic [NUM_FUNCS-1:0] [SEL_W-1:0] sel;
    } rmisb_sel_s;

endpackage : rmisb_pkg

// [hdl/rmisb_lock.sv]
/*
 * write-lock keeper: tracks the two-key unlock sequence on the lock control
 * word and holds the remap write lock, with the one-shot lock option.
 * assumes bus strobes are single cycle and synchronous to ref_clk.
 */
`timescale 1ns/100ps
module rmisb_lock
    import rmisb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // configuration
    input wire logic one_shot_lock_option,
    // bus
    input wire rmisb_bus_s bus,
    // state
    output logic remap_write_lock
);

    rmisb_key_e key_q;
    logic set_once_q;
    logic ctrl_wr;

    assign ctrl_wr = bus.wr && (bus.addr == OFS_LOCK_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // key sequence: 46h then 57h, then one lock write
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            key_q <= KEY_IDLE;
        else if (ctrl_wr)
        begin
            case (key_q)
                KEY_IDLE: key_q <= (bus.wdata[7:0] == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
                KEY_GOT1: key_q <= (bus.wdata[7:0] == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
                KEY_OPEN: key_q <= KEY_IDLE;
                default: key_q <= KEY_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock bit; resets unlocked
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            remap_write_lock <= 1'b0;
            set_once_q <= 1'b0;
        end
        else if (ctrl_wr && key_q == KEY_OPEN)
        begin
            if (bus.wdata[LOCK_BIT])
            begin
                remap_write_lock <= 1'b1;
                set_once_q <= 1'b1;
            end
            else if (!(one_shot_lock_option && set_once_q))
                remap_write_lock <= 1'b0;
        end
    end

endmodule : rmisb_lock

// [hdl/rmisb_route.sv]
/*
 * routing mux: one pin selector per peripheral input function.
 * assumes pin inputs are already synchronous to the clock.
 */
`timescale 1ns/100ps
module rmisb_route
    import rmisb_pkg::*;
#(
    parameter int unsigned PINS_PRESENT = 26
)
(
    // selectors
    input wire rmisb_sel_s sel,
    // pins and functions
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_FUNCS-1:0] idle_level,
    output logic [NUM_FUNCS-1:0] func_in
);

    genvar g;
    generate
        for (g = 0; g < NUM_FUNCS; g++)
        begin : g_func
            // absent pin gives inactive level
            assign func_in[g] = (32'(sel.sel[g]) < PINS_PRESENT) ?
                pin_in[sel.sel[g]] : idle_level[g];
        end
    endgenerate

endmodule : rmisb_route

// [testbench/rmisb_pin_model.sv]
/*
 * pin-side model: holds the remappable pin levels and the inactive levels of
 * the peripheral inputs, changing pins only on reset or when the bench loads a pattern.
 * assumes load is driven off the sampling edge of ref_clk.
 */
`timescale 1ns/100ps
module rmisb_pin_model
    import rmisb_pkg::*;
#(
    parameter logic [NUM_FUNCS-1:0] IDLE_PAT = 28'h5a3c96e
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pattern load
    input wire logic load,
    input wire logic [NUM_PINS-1:0] pat,
    // pins and inactive levels
    output logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_FUNCS-1:0] idle_level
);
    assign idle_level = IDLE_PAT;

    // pins are synchronous to the clock
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_in <= 32'ha5c3_0f96;
        else if (load)
            pin_in <= pat;
    end
endmodule : rmisb_pin_model

// [testbench/testbench.sv]
/*
 * self-checking bench for the remappable input select bank.
 * assumes the register port and pins are driven by this bench and the
 * pin model, all synchronous to ref_clk.
 */
`timescale 1ns/100ps
module testbench;
    import rmisb_pkg::*;
    localparam int PINS = 26;
    localparam logic [NUM_FUNCS-1:0] IDLE = 28'h5a3c96e;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic opt = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_FUNCS-1:0] idle_level;
    logic [NUM_FUNCS-1:0] func_in_q;
    logic lock_q;
    logic mism_q;
    logic pin_load = 1'b0;
    logic [NUM_PINS-1:0] pin_pat = '0;
    int err_total = 0;
    int checks = 0;
    // which input registers carry a high and a low selector field
    logic [13:0] reg_hi = 14'h17bd;
    logic [13:0] reg_lo = 14'h3ffe;
    // per function: field half and owning register
    logic [22:0] f_hi = 23'h2552a9;
    int f_reg[23] = '{0, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 7, 7, 8, 8, 9, 9, 10, 10, 11, 12, 12, 13};
    logic [4:0] sel_v[23];
    logic [DATA_W-1:0] rv;

    always #4 ref_clk = ~ref_clk;

    rmisb_top #(.PINS_PRESENT(PINS)) uut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .one_shot_lock_option(opt),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .idle_level(idle_level),
        .func_in_q(func_in_q), .remap_write_lock_q(lock_q), .mismatch_reset_q(mism_q)
    );

    rmisb_pin_model #(.IDLE_PAT(IDLE)) partner
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .load(pin_load), .pat(pin_pat),
        .pin_in(pin_in), .idle_level(idle_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd_reg

    task automatic lock_cmd(input logic v);
        wr_reg(OFS_LOCK_CTRL, 16'h0046);
        wr_reg(OFS_LOCK_CTRL, 16'h0057);
        wr_reg(OFS_LOCK_CTRL, {9'h0, v, 6'h0});
        repeat (2) @(posedge ref_clk);
    endtask : lock_cmd

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // pin levels, then routed value per function, then unused functions low
    task automatic check_route(input logic [NUM_PINS-1:0] pat);
        @(posedge ref_clk);
        pin_pat <= pat;
        pin_load <= 1'b1;
        @(posedge ref_clk);
        pin_load <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        for (int f = 0; f < 23; f++)
            check($sformatf("func %0d", f), func_in_q[f],
                  (sel_v[f] < PINS) ? pat[sel_v[f]] : IDLE[f]);
        check("unused funcs", func_in_q[27:23], 5'h00);
    endtask : check_route

    task automatic program_sel(input int k);
        logic [DATA_W-1:0] v;
        for (int f = 0; f < 23; f++)
            sel_v[f] = 5'((f * 5 + k) % 32);
        for (int r = 0; r < 14; r++)
        begin
            v = '0;
            for (int f = 0; f < 23; f++)
                if (f_reg[f] == r)
                    v = v | (f_hi[f] ? {3'h0, sel_v[f], 8'h00} : {11'h0, sel_v[f]});
            wr_reg(6'(r), v);
            rd_reg(6'(r), rv);
            check($sformatf("sel reg %0d", r), rv, v);
        end
    endtask : program_sel

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int r = 0; r < 14; r++)
        begin
            rd_reg(6'(r), rv);
            check($sformatf("reset reg %0d", r), rv,
                  {3'h0, {5{reg_hi[r]}}, 3'h0, {5{reg_lo[r]}}});
        end
        for (int r = 0; r < 13; r++)
        begin
            rd_reg(6'(16 + r), rv);
            check("out reg reset", rv, 16'h0000);
        end
        check("lock after reset", lock_q, 1'b0);
        for (int f = 0; f < 23; f++)
            sel_v[f] = 5'h1f;
        check_route(32'hffff_ffff);
    endtask : t_reset

    task automatic t_fields();
        for (int r = 0; r < 14; r++)
        begin
            wr_reg(6'(r), 16'hffff);
            rd_reg(6'(r), rv);
            check($sformatf("field mask %0d", r), rv,
                  {3'h0, {5{reg_hi[r]}}, 3'h0, {5{reg_lo[r]}}});
        end
        wr_reg(6'h0e, 16'hffff);
        rd_reg(6'h0e, rv);
        check("unmapped read", rv, 16'h0000);
        rd_reg(6'h3f, rv);
        check("unmapped high read", rv, 16'h0000);
    endtask : t_fields

    task automatic t_route();
        program_sel(1);
        check_route(32'h3c5a_9617);
        check_route(~32'h3c5a_9617);
        program_sel(4);
        check_route(32'h0f0f_c3a5);
    endtask : t_route

    task automatic t_lock();
        lock_cmd(1'b1);
        check("lock set", lock_q, 1'b1);
        rd_reg(OFS_LOCK_CTRL, rv);
        check("lock readback", rv, 16'h0040);
        wr_reg(6'h02, 16'h0000);
        rd_reg(6'h02, rv);
        check("locked write held", rv, {3'h0, sel_v[3], 3'h0, sel_v[2]});
        wr_reg(6'h10, 16'h0101);
        rd_reg(6'h10, rv);
        check("locked out write held", rv, 16'h0000);
        wr_reg(OFS_LOCK_CTRL, 16'h0046);
        wr_reg(OFS_LOCK_CTRL, 16'h0012);
        wr_reg(OFS_LOCK_CTRL, 16'h0000);
        repeat (2) @(posedge ref_clk);
        check("broken key", lock_q, 1'b1);
        lock_cmd(1'b0);
        check("lock clear", lock_q, 1'b0);
        wr_reg(6'h02, 16'h0a05);
        rd_reg(6'h02, rv);
        check("unlocked write", rv, 16'h0a05);
        wr_reg(6'h10, 16'hffff);
        rd_reg(6'h10, rv);
        check("out reg write", rv, 16'h1f1f);
    endtask : t_lock

    task automatic t_one_shot();
        @(posedge ref_clk);
        opt <= 1'b1;
        lock_cmd(1'b1);
        lock_cmd(1'b0);
        check("one shot lock held", lock_q, 1'b1);
        wr_reg(6'h02, 16'h0000);
        rd_reg(6'h02, rv);
        check("one shot write held", rv, 16'h0a05);
        @(posedge ref_clk);
        do_reset();
        opt <= 1'b0;
        check("lock after reset", lock_q, 1'b0);
        rd_reg(6'h02, rv);
        check("reg after reset", rv, 16'h1f1f);
    endtask : t_one_shot

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end

    initial
    begin
        do_reset();
        t_reset();
        t_fields();
        t_route();
        t_lock();
        t_one_shot();
        check("mismatch flag", mism_q, 1'b0);
        rd_reg(OFS_STATUS, rv);
        check("status reg", rv, 16'h0000);
        finish_test();
    end
endmodule : testbench
